// ---- rtl/otis_defs.vh ----
`ifndef OTIS_DEFS_VH
`define OTIS_DEFS_VH
// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define OTIS_ADDR_CFG     12'h000
`define OTIS_ADDR_STATUS  12'h004
`define OTIS_ADDR_INTSTAT 12'h008
`define OTIS_ADDR_INTMASK 12'h00c
// ----------------------------------------------------------------------
// Setting encodings and reset values
// ----------------------------------------------------------------------
`define OTIS_MODE_INHIBIT 2'h0
`define OTIS_MODE_IGNORE  2'h1
`define OTIS_MODE_FAULT   2'h2
`define OTIS_MODE_RESET   2'h1
`define OTIS_SEQ_BRAKE    2'h0
`define OTIS_SEQ_ZTORQUE  2'h1
`define OTIS_SEQ_ESTOP    2'h2
`define OTIS_SEQ_RESET    2'h0
// Last count of the synchroniser fill before the settings are captured.
`define OTIS_FILL_LAST    2'h3
// ----------------------------------------------------------------------
// Interrupt bit positions
// ----------------------------------------------------------------------
`define OTIS_IRQ_POS   0
`define OTIS_IRQ_NEG   1
`define OTIS_IRQ_FAULT 2
`define OTIS_IRQ_W     3
`define OTIS_FAULT_CODE 8'h26
`endif

// ---- rtl/otis_seq.v ----
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "otis_defs.vh"
module otis_seq (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_positive_limit_input,
  input wire i_negative_limit_input,
  input wire [1:0] i_limit_input_mode,
  input wire [1:0] i_limit_stop_sequence,
  input wire i_cmd_pos,
  input wire i_cmd_neg,
  input wire i_stalled,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_move_pos,
  output reg o_move_neg,
  output reg o_short_circuit_braking,
  output reg o_zero_torque_pos,
  output reg o_zero_torque_neg,
  output reg o_emergency_stop,
  output reg o_hold_deviation,
  output reg o_limit_input_fault,
  output reg [7:0] o_fault_code,
  output reg o_irq
);
  // ----------------------------------------------------------------------
  // Stop phase states
  // ----------------------------------------------------------------------
  localparam ST_RUN = 3'b001;
  localparam ST_DECEL = 3'b010;
  localparam ST_STALL = 3'b100;

  wire pos_s;
  wire neg_s;
  wire [1:0] mode_s0;
  wire [1:0] mode_s1;
  wire [1:0] seq_s0;
  wire [1:0] seq_s1;
  wire stall_s;
  reg [1:0] mode_r;
  reg [1:0] seq_r;
  reg latch_done_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`OTIS_IRQ_W-1:0] stat_r;
  reg [`OTIS_IRQ_W-1:0] mask_r;
  reg pos_d_r;
  reg neg_d_r;
  reg fault_d_r;
  wire inhibit_pos;
  wire inhibit_neg;
  wire inhibit_any;
  wire fault_now;
  wire [`OTIS_IRQ_W-1:0] events;
  wire [`OTIS_IRQ_W-1:0] w1c;
  wire wr_acc;
  wire rd_setup;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  otis_sync u_pos (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_positive_limit_input), .o_sync(pos_s));
  otis_sync u_neg (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_negative_limit_input), .o_sync(neg_s));
  otis_sync u_m0 (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_limit_input_mode[0]), .o_sync(mode_s0[0]));
  otis_sync u_m1 (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_limit_input_mode[1]), .o_sync(mode_s0[1]));
  otis_sync u_q0 (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_limit_stop_sequence[0]), .o_sync(seq_s0[0]));
  otis_sync u_q1 (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_limit_stop_sequence[1]), .o_sync(seq_s0[1]));
  otis_sync u_st (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_stalled), .o_sync(stall_s));
  assign mode_s1 = mode_s0;
  assign seq_s1 = seq_s0;

  // ----------------------------------------------------------------------
  // Power-on latch of the settings
  // ----------------------------------------------------------------------
  // The settings are captured once, after the synchronisers have filled,
  // and never again until the next reset.
  reg [1:0] fill_r;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= `OTIS_MODE_RESET;
      seq_r <= `OTIS_SEQ_RESET;
      latch_done_r <= 1'b0;
      fill_r <= 2'h0;
    end else if (!latch_done_r) begin
      if (fill_r == `OTIS_FILL_LAST) begin
        mode_r <= mode_s1;
        seq_r <= seq_s1;
        latch_done_r <= 1'b1;
      end else begin
        fill_r <= fill_r + 2'h1;
      end
    end
  end

  // Inhibit applies per direction only in mode 0 once the latch is done.
  assign inhibit_pos = latch_done_r && (mode_r == `OTIS_MODE_INHIBIT) &&
    pos_s;
  assign inhibit_neg = latch_done_r && (mode_r == `OTIS_MODE_INHIBIT) &&
    neg_s;
  assign inhibit_any = inhibit_pos | inhibit_neg;
  assign fault_now = latch_done_r && (mode_r == `OTIS_MODE_FAULT) &&
    (pos_s | neg_s);

  // ----------------------------------------------------------------------
  // Stop phase sequencer
  // ----------------------------------------------------------------------
  // Moves from run to deceleration on an inhibit, to stalled on standstill.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (inhibit_any) begin
          state_nxt = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (!inhibit_any) begin
          state_nxt = ST_RUN;
        end else if (stall_s) begin
          state_nxt = ST_STALL;
        end
      end
      ST_STALL: begin
        if (!inhibit_any) begin
          state_nxt = ST_RUN;
        end else if (!stall_s) begin
          state_nxt = ST_DECEL;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stop outputs per sequence value and phase.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_short_circuit_braking <= 1'b0;
      o_zero_torque_pos <= 1'b0;
      o_zero_torque_neg <= 1'b0;
      o_emergency_stop <= 1'b0;
      o_hold_deviation <= 1'b0;
    end else begin
      o_short_circuit_braking <= (state_r == ST_DECEL) &&
        (seq_r == `OTIS_SEQ_BRAKE);
      o_emergency_stop <= (state_r == ST_DECEL) &&
        (seq_r == `OTIS_SEQ_ESTOP);
      o_zero_torque_pos <= inhibit_pos && ((state_r == ST_STALL) ||
        (seq_r == `OTIS_SEQ_ZTORQUE));
      o_zero_torque_neg <= inhibit_neg && ((state_r == ST_STALL) ||
        (seq_r == `OTIS_SEQ_ZTORQUE));
      o_hold_deviation <= (state_r != ST_RUN) &&
        (seq_r != `OTIS_SEQ_ESTOP);
    end
  end

  // Motion gating: an inhibit drops only the blocked direction; a fault drops both.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_move_pos <= 1'b0;
      o_move_neg <= 1'b0;
    end else begin
      o_move_pos <= i_cmd_pos && !inhibit_pos && !fault_now;
      o_move_neg <= i_cmd_neg && !inhibit_neg && !fault_now;
    end
  end

  // Fault indication is a level while either limit is active in mode 2.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_limit_input_fault <= 1'b0;
      o_fault_code <= 8'h00;
    end else begin
      o_limit_input_fault <= fault_now;
      o_fault_code <= fault_now ? `OTIS_FAULT_CODE : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign w1c = (wr_acc && (i_paddr == `OTIS_ADDR_INTSTAT)) ?
    i_pwdata[`OTIS_IRQ_W-1:0] : {`OTIS_IRQ_W{1'b0}};
  assign events = {fault_now & ~fault_d_r, inhibit_neg & ~neg_d_r,
    inhibit_pos & ~pos_d_r};

  // Set wins over a write-one clear in the same cycle.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_r <= {`OTIS_IRQ_W{1'b0}};
      mask_r <= {`OTIS_IRQ_W{1'b0}};
      pos_d_r <= 1'b0;
      neg_d_r <= 1'b0;
      fault_d_r <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      pos_d_r <= inhibit_pos;
      neg_d_r <= inhibit_neg;
      fault_d_r <= fault_now;
      stat_r <= (stat_r & ~w1c) | events;
      if (wr_acc && (i_paddr == `OTIS_ADDR_INTMASK)) begin
        mask_r <= i_pwdata[`OTIS_IRQ_W-1:0];
      end
      o_irq <= |(((stat_r & ~w1c) | events) & mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: no wait states, read data latched in setup
  // ----------------------------------------------------------------------
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable &&
        (i_paddr != `OTIS_ADDR_CFG) && (i_paddr != `OTIS_ADDR_STATUS) &&
        (i_paddr != `OTIS_ADDR_INTSTAT) && (i_paddr != `OTIS_ADDR_INTMASK);
      if (rd_setup) begin
        case (i_paddr)
          `OTIS_ADDR_CFG: o_prdata <= {27'h0, latch_done_r, seq_r, mode_r};
          `OTIS_ADDR_STATUS: o_prdata <= {27'h0, state_r, neg_s, pos_s};
          `OTIS_ADDR_INTSTAT: o_prdata <= {29'h0, stat_r};
          `OTIS_ADDR_INTMASK: o_prdata <= {29'h0, mask_r};
          default: o_prdata <= 32'h00000000;
        endcase
      end else begin
        o_prdata <= 32'h00000000;
      end
    end
  end
endmodule // otis_seq
`default_nettype wire

// ---- rtl/otis_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// Two-flip-flop synchroniser for an asynchronous level.
module otis_sync (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_async,
  output wire o_sync
);
  reg meta_r;
  reg sync_r;
  // Only the second stage is ever read downstream.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule // otis_sync
`default_nettype wire

// ---- testbench/otis_machine.sv ----
`timescale 1ns/1ps
`default_nettype none
module otis_machine #(parameter int LIM = 8) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_move_pos,
  input wire logic i_move_neg,
  input wire logic [3:0] i_lag,
  output logic o_pos_lim,
  output logic o_neg_lim,
  output logic o_stalled
);
  int pos_r = 0;
  logic [3:0] idle_r = 4'h0;
  // Axis follows the gated motion; idle counts the coasting time.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_r <= 0;
      idle_r <= 4'h0;
    end else begin
      pos_r <= pos_r + int'(i_move_pos) - int'(i_move_neg);
      if (i_move_pos || i_move_neg) idle_r <= 4'h0;
      else if (idle_r != 4'hf) idle_r <= idle_r + 4'h1;
    end
  end
  // Switches close at or past either end; stall shows once coasting is over.
  assign o_pos_lim = pos_r >= LIM;
  assign o_neg_lim = pos_r <= -LIM;
  assign o_stalled = !(i_move_pos || i_move_neg) && idle_r >= i_lag;
endmodule // otis_machine
`default_nettype wire

// ---- testbench/otis_seq_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module otis_seq_assertions (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_positive_limit_input,
  input wire logic i_negative_limit_input,
  input wire logic [1:0] i_limit_input_mode,
  input wire logic [1:0] i_limit_stop_sequence,
  input wire logic i_cmd_pos,
  input wire logic i_cmd_neg,
  input wire logic i_stalled,
  input wire logic o_move_pos,
  input wire logic o_move_neg,
  input wire logic o_short_circuit_braking,
  input wire logic o_zero_torque_pos,
  input wire logic o_emergency_stop,
  input wire logic o_hold_deviation,
  input wire logic o_limit_input_fault,
  input wire logic [7:0] o_fault_code
);
  logic [2:0] n_r;
  logic [1:0] m_r, s_r;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Settings copy taken at the fourth edge; a mode of 3 means not yet.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      n_r <= 3'h0;
      m_r <= 2'h3;
      s_r <= 2'h0;
    end else if (n_r != 3'h4) begin
      n_r <= n_r + 3'h1;
      if (n_r == 3'h3) begin
        m_r <= i_limit_input_mode;
        s_r <= i_limit_stop_sequence;
      end
    end
  end
  a_pos_blocked: assert property (
    (m_r == 2'h0 && i_positive_limit_input)[*5] |=> !o_move_pos)
    else $error("Motion into limit.");
  a_ignore_pass: assert property (
    (m_r == 2'h1 && i_cmd_pos)[*4] |=> o_move_pos) else $error("Blocked.");
  a_fault_raise: assert property (
    (m_r == 2'h2 && (i_positive_limit_input || i_negative_limit_input))[*4]
    |=> o_limit_input_fault) else $error("No fault.");
  a_fault_code: assert property (
    o_limit_input_fault |-> o_fault_code == 8'h26) else $error("Bad code.");
  a_only_mode0: assert property (
    (m_r == 2'h1 || m_r == 2'h2) |-> !(o_short_circuit_braking ||
    o_emergency_stop || o_zero_torque_pos || o_hold_deviation))
    else $error("Stop outside mode 0.");
  a_decel_kind: assert property (
    (o_short_circuit_braking || o_emergency_stop) |-> m_r == 2'h0 &&
    s_r == (o_emergency_stop ? 2'h2 : 2'h0)) else $error("Wrong decel.");
  a_stall_zero: assert property (
    (m_r == 2'h0 && i_positive_limit_input && i_stalled)[*5]
    |=> o_zero_torque_pos && (o_hold_deviation == (s_r != 2'h2)))
    else $error("Wrong stall state.");
  a_back_off: assert property (
    (m_r == 2'h0 && i_cmd_neg && !i_negative_limit_input)[*5]
    |=> o_move_neg) else $error("Back off refused.");
endmodule // otis_seq_assertions
bind otis_seq otis_seq_assertions otis_seq_assertions_inst (.*);
`default_nettype wire

// ---- testbench/otis_seq_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module otis_seq_bench;
  logic clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, cp = 0, cn = 0;
  logic [1:0] md = 2'h1, sq = 2'h0;
  logic [3:0] lag = 4'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rd, rv;
  logic pl, nl, st, rdy, err, ev, mp, mn, br, zp, zn, es, hd, flt, irq, r1;
  logic [7:0] code;
  int miscompares = 0, checked = 0;
  // The 20 MHz clock.
  always #25 clk = ~clk;
  otis_seq otis_seq_inst (.i_clock(clk), .i_rst_n(rst_n),
    .i_positive_limit_input(pl), .i_negative_limit_input(nl),
    .i_limit_input_mode(md), .i_limit_stop_sequence(sq), .i_cmd_pos(cp),
    .i_cmd_neg(cn), .i_stalled(st), .i_psel(sel), .i_penable(en),
    .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd), .o_prdata(rd),
    .o_pready(rdy), .o_pslverr(err), .o_move_pos(mp), .o_move_neg(mn),
    .o_short_circuit_braking(br), .o_zero_torque_pos(zp),
    .o_zero_torque_neg(zn), .o_emergency_stop(es), .o_hold_deviation(hd),
    .o_limit_input_fault(flt), .o_fault_code(code), .o_irq(irq));
  otis_machine otis_machine_inst (.i_clock(clk), .i_rst_n(rst_n),
    .i_move_pos(mp), .i_move_neg(mn), .i_lag(lag), .o_pos_lim(pl),
    .o_neg_lim(nl), .o_stalled(st));
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A wait that ran out ends the run.
  task automatic hang(input string n, input logic ok);
    chk(n, ok, 1'b1);
    if (ok !== 1'b1) give_verdict;
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
    hang("ready", rdy === 1'b1);
    rv = rd;
    ev = err;
    sel <= 1'b0;
    en <= 1'b0;
  endtask
  // Power-up with the given settings, then drive each pin to 2 minus its setting.
  task automatic pwr(input logic [1:0] m, s);
    @(posedge clk);
    rst_n <= 1'b0;
    cp <= 1'b0;
    cn <= 1'b0;
    md <= m;
    sq <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg", rv, {27'h0, 1'b1, s, m});
    md <= 2'h2 - m;
    sq <= 2'h2 - s;
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg kept", rv, {27'h0, 1'b1, s, m});
  endtask
  // Drive into the positive switch, stall, clear the event, back off.
  task automatic inhibit(input logic [1:0] s, input logic [3:0] l);
    int i;
    pwr(2'h0, s);
    lag <= l;
    cp <= 1'b1;
    for (i = 0; i < 99 && !(pl === 1'b1 && mp === 1'b0); i++) @(posedge clk);
    hang("decel", pl === 1'b1 && mp === 1'b0);
    @(posedge clk);
    chk("braking", br, s == 2'h0);
    chk("e-stop", es, s == 2'h2);
    chk("decel torque", zp, s == 2'h1);
    for (i = 0; i < 99 && !(st === 1'b1 && pl === 1'b1); i++) @(posedge clk);
    hang("stall", st === 1'b1 && pl === 1'b1);
    repeat (4) @(posedge clk);
    chk("zero torque", zp, 1'b1);
    chk("move", mp, 1'b0);
    chk("hold", hd, s != 2'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", rv[4:0], 5'h11);
    apb(1'b1, 12'h00c, 32'h7);
    repeat (2) @(posedge clk);
    r1 = irq;
    apb(1'b1, 12'h00c, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq on", r1, 1'b1);
    chk("irq off", irq, 1'b0);
    apb(1'b1, 12'h008, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk("cleared", rv[2:0], 3'h0);
    cp <= 1'b0;
    cn <= 1'b1;
    for (i = 0; i < 99 && mn !== 1'b1; i++) @(posedge clk);
    hang("back off", mn === 1'b1);
    repeat (6) @(posedge clk);
    chk("still backing", mn, 1'b1);
    chk("off switch", pl, 1'b0);
    cn <= 1'b0;
  endtask
  // Drive into the negative switch under zero torque, then back off.
  task automatic neg_side;
    int i;
    pwr(2'h0, 2'h1);
    cn <= 1'b1;
    for (i = 0; i < 99 && !(nl === 1'b1 && mn === 1'b0); i++) @(posedge clk);
    hang("neg stop", nl === 1'b1 && mn === 1'b0);
    @(posedge clk);
    chk("zero torque neg", zn, 1'b1);
    chk("zero torque pos", zp, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk("neg event", rv[2:0], 3'h2);
    cn <= 1'b0;
    cp <= 1'b1;
    for (i = 0; i < 99 && mp !== 1'b1; i++) @(posedge clk);
    hang("neg back off", mp === 1'b1);
    cp <= 1'b0;
  endtask
  // Limits ignored in mode 1; fault in mode 2; an unmapped read.
  task automatic other_modes;
    int i;
    pwr(2'h1, 2'h0);
    cp <= 1'b1;
    for (i = 0; i < 99 && pl !== 1'b1; i++) @(posedge clk);
    hang("limit", pl === 1'b1);
    repeat (4) @(posedge clk);
    chk("ignored", mp, 1'b1);
    chk("no stop", zp, 1'b0);
    pwr(2'h2, 2'h1);
    cp <= 1'b1;
    for (i = 0; i < 99 && flt !== 1'b1; i++) @(posedge clk);
    hang("fault", flt === 1'b1);
    chk("code", code, 8'h26);
    chk("no stop", zp, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk("fault event", rv[2], 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {ev, rv[30:0]}, 32'h80000000);
  endtask
  // Main sequence.
  initial begin
    inhibit(2'h0, 4'h0);
    inhibit(2'h1, 4'h6);
    inhibit(2'h2, 4'h3);
    other_modes;
    neg_side;
    give_verdict;
  end
endmodule // otis_seq_bench
`default_nettype wire
